// ===== hw/lcpwm_fifo.sv
`timescale 1ns/1ps
module lcpwm_fifo
  import lcpwm_pkg::*;
#(
  parameter int W = 1,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_rst_n,
  input wire logic i_flush,
  lcpwm_fifo_if.fifo f
);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [W-1:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic full, empty, push, pop, load;

  // Count uses an extra pointer bit so full and empty are exact
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign empty = (wr_ptr == rd_ptr);
  assign f.in_ready = !full;
  assign f.out_valid = rvalid;
  assign f.out_data = rdata;
  assign push = f.in_valid && !full;
  // Output register refills when empty or being taken
  assign load = !empty && (!rvalid || f.out_ready);
  assign pop = load;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_rdata = load ? mem[rd_ptr[AW-1:0]] : rdata;
    next_rvalid = load ? 1'b1 : (f.out_ready ? 1'b0 : rvalid);
    if (i_flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_rvalid = 1'b0;
    end
  end

  // Storage and pointers; flush empties it on each new frame
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
    end else if (i_ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= f.in_data;
      end
    end
  end
endmodule : lcpwm_fifo

// ===== hw/lcpwm_fifo_if.sv
`timescale 1ns/1ps
interface lcpwm_fifo_if #(parameter int W = 1);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : lcpwm_fifo_if

// ===== hw/lcpwm_pkg.sv
package lcpwm_pkg;
  // Channel count and field widths
  localparam int NUM_CH = 16;
  localparam int GS_W = 12;
  localparam int DC_W = 6;
  localparam int GS_FRAME = 192;
  localparam int DC_FRAME = 96;
  localparam int SHIFT_W = 192;
  // Nonvolatile default current scale (all ones)
  localparam logic [5:0] DC_DEFAULT = 6'h3F;
  localparam logic [11:0] GS_CNT_START = 12'h000;
  // Stagger between neighbouring channels
  localparam int CLK_PERIOD_NS = 40;
  localparam int STAGGER_NS = 20;
  // Shortest step is one cycle, so 20 ns rounds up to one clock per channel
  localparam int STAGGER_CYC = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_DEPTH = (NUM_CH - 1) * STAGGER_CYC + 1;
  // Status FIFO shape
  localparam int FIFO_W = 1;
  localparam int FIFO_D = 16;
  localparam int FIFO_AW = 4;

  // Channel slice of a packed word, channel 0 in the low bits
  function automatic logic [11:0] lcpwm_gs_of(input logic [191:0] v, input int ch);
    lcpwm_gs_of = v[ch*GS_W +: GS_W];
  endfunction : lcpwm_gs_of

  function automatic logic [5:0] lcpwm_dc_of(input logic [95:0] v, input int ch);
    lcpwm_dc_of = v[ch*DC_W +: DC_W];
  endfunction : lcpwm_dc_of
endpackage : lcpwm_pkg

// ===== hw/lcpwm_top.sv
`timescale 1ns/1ps
module lcpwm_top
  import lcpwm_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_SHIFT_CLK,
  input wire logic I_SERIAL_IN_PIN,
  input wire logic I_LATCH_STROBE,
  input wire logic I_PROGRAMMING_MODE_INPUT,
  input wire logic I_PROG_LEVEL,
  input wire logic I_CURRENT_SCALE_SOURCE_SELECT,
  input wire logic I_BLANK,
  input wire logic I_GS_REF_CLK,
  input wire logic [15:0] I_OPEN_LED_DETECT,
  input wire logic I_OVERTEMP_FLAG,
  output logic O_SERIAL_OUT_PIN,
  output logic [15:0] O_CHANNEL_SINK_OUTPUT,
  output logic [95:0] O_CURRENT_SCALE_SETTING,
  output logic O_ERROR_FLAG_OUTPUT_O,
  output logic O_ERROR_FLAG_OUTPUT_OE,
  output logic O_STATUS_VALID
);
  typedef enum logic [2:0] {
    LCPWM_IDLE = 3'b001,
    LCPWM_LATCH = 3'b010,
    LCPWM_PROG = 3'b100
  } lcpwm_state_t;

  // Two-flop synchronisers for all pins from outside the clock domain
  logic [7:0] sync1, sync2;
  logic [15:0] lod_s1, lod_s2;
  logic sclk_d, gsclk_d;
  logic ot_s1, ot_s2;
  logic sclk, sdin, latch, mode, prog, srcsel, blank, gsclk;
  assign sclk = sync2[0];
  assign sdin = sync2[1];
  assign latch = sync2[2];
  assign mode = sync2[3];
  assign prog = sync2[4];
  assign srcsel = sync2[5];
  assign blank = sync2[6];
  assign gsclk = sync2[7];

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      lod_s1 <= 16'h0000;
      lod_s2 <= 16'h0000;
      sclk_d <= 1'b0;
      gsclk_d <= 1'b0;
      ot_s1 <= 1'b0;
      ot_s2 <= 1'b0;
    end else if (I_CE) begin
      sync1 <= {I_GS_REF_CLK, I_BLANK, I_CURRENT_SCALE_SOURCE_SELECT, I_PROG_LEVEL,
                I_PROGRAMMING_MODE_INPUT, I_LATCH_STROBE, I_SERIAL_IN_PIN, I_SHIFT_CLK};
      sync2 <= sync1;
      lod_s1 <= I_OPEN_LED_DETECT;
      lod_s2 <= lod_s1;
      sclk_d <= sclk;
      gsclk_d <= gsclk;
      ot_s1 <= I_OVERTEMP_FLAG;
      ot_s2 <= ot_s1;
    end
  end

  logic sclk_rise, gsclk_rise, latch_fall, latch_d;
  assign sclk_rise = sclk && !sclk_d;
  assign gsclk_rise = gsclk && !gsclk_d;
  assign latch_fall = latch_d && !latch;

  // Shift register, grayscale and scale registers, nonvolatile copy
  logic [191:0] shreg, next_shreg;
  logic [191:0] gs_reg, next_gs_reg;
  logic [95:0] dc_reg, next_dc_reg;
  logic [95:0] dc_nv, next_dc_nv;
  logic [15:0] status, next_status;
  logic [7:0] bitcnt, next_bitcnt;
  lcpwm_state_t state, next_state;

  // Status FIFO feeds the shift register tail after a latch
  lcpwm_fifo_if #(.W(FIFO_W)) stq ();
  logic [4:0] load_idx, next_load_idx;
  logic flush;
  assign flush = latch_fall;
  assign stq.in_valid = (load_idx != 5'h00);
  assign stq.in_data = status[load_idx[3:0] - 4'h1];
  assign stq.out_ready = sclk_rise;

  lcpwm_fifo #(.W(FIFO_W), .D(FIFO_D), .AW(FIFO_AW)) u_fifo (
    .i_clk(I_REF_CLK),
    .i_ce(I_CE),
    .i_rst_n(I_RST_N),
    .i_flush(flush),
    .f(stq.fifo)
  );

  always_comb begin
    next_shreg = shreg;
    next_gs_reg = gs_reg;
    next_dc_reg = dc_reg;
    next_dc_nv = dc_nv;
    next_status = status;
    next_bitcnt = bitcnt;
    next_state = state;
    next_load_idx = load_idx;
    if (stq.in_valid && stq.in_ready) begin
      next_load_idx = load_idx - 5'h01;
    end
    // Rising shift clock takes one bit, MSB first; status bit enters if queued
    if (sclk_rise) begin
      next_shreg = {shreg[190:0], stq.out_valid ? stq.out_data[0] : sdin};
      next_bitcnt = (bitcnt == 8'hFF) ? bitcnt : bitcnt + 8'h01;
    end
    case (state)
      LCPWM_IDLE: begin
        if (latch) begin
          next_state = LCPWM_LATCH;
        end else if (prog && srcsel) begin
          next_state = LCPWM_PROG;
        end
      end
      LCPWM_LATCH: begin
        // Transparent while latch high; frame length set by host
        if (!mode) begin
          next_gs_reg = shreg;
        end else begin
          next_dc_reg = shreg[95:0];
        end
        if (!latch) begin
          next_state = LCPWM_IDLE;
        end
      end
      LCPWM_PROG: begin
        next_dc_nv = dc_reg;
        if (!(prog && srcsel)) begin
          next_state = LCPWM_IDLE;
        end
      end
      default: next_state = LCPWM_IDLE;
    endcase
    // Status captured when latch falls; queued for shift out
    if (latch_fall) begin
      next_status = lod_s2;
      next_load_idx = 5'h10;
      next_bitcnt = 8'h00;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      shreg <= '0;
      gs_reg <= '0;
      dc_reg <= '0;
      dc_nv <= {NUM_CH{DC_DEFAULT}};
      status <= 16'h0000;
      bitcnt <= 8'h00;
      state <= LCPWM_IDLE;
      load_idx <= 5'h00;
      latch_d <= 1'b0;
    end else if (I_CE) begin
      shreg <= next_shreg;
      gs_reg <= next_gs_reg;
      dc_reg <= next_dc_reg;
      dc_nv <= next_dc_nv;
      status <= next_status;
      bitcnt <= next_bitcnt;
      state <= next_state;
      load_idx <= next_load_idx;
      latch_d <= latch;
    end
  end

  // Grayscale counter on its own reference clock edge, cleared by blank
  logic [11:0] gs_cnt, next_gs_cnt;
  logic [15:0] pwm_raw, next_pwm_raw;
  logic [DLY_DEPTH-1:0] dly [NUM_CH];
  always_comb begin
    next_gs_cnt = gs_cnt;
    if (blank) begin
      next_gs_cnt = GS_CNT_START;
    end else if (gsclk_rise && gs_cnt != 12'hFFF) begin
      next_gs_cnt = gs_cnt + 12'h001;
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_pwm_raw[ch] = !blank && (gs_cnt < lcpwm_gs_of(gs_reg, ch));
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      gs_cnt <= GS_CNT_START;
      pwm_raw <= 16'h0000;
      for (int ch = 0; ch < NUM_CH; ch++) begin
        dly[ch] <= '0;
      end
    end else if (I_CE) begin
      gs_cnt <= next_gs_cnt;
      pwm_raw <= next_pwm_raw;
      // Delay line per channel; channel n taps n stagger steps later
      for (int ch = 0; ch < NUM_CH; ch++) begin
        dly[ch] <= {dly[ch][DLY_DEPTH-2:0], pwm_raw[ch]};
      end
    end
  end

  // Outputs registered; blank kills outputs at once rather than waiting
  logic [15:0] next_out;
  logic [95:0] next_scale;
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_out[ch] = !blank && dly[ch][ch*STAGGER_CYC];
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_scale[ch*DC_W +: DC_W] = srcsel ? lcpwm_dc_of(dc_reg, ch)
                                           : lcpwm_dc_of(dc_nv, ch);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_CHANNEL_SINK_OUTPUT <= 16'h0000;
      O_CURRENT_SCALE_SETTING <= {NUM_CH{DC_DEFAULT}};
      O_SERIAL_OUT_PIN <= 1'b0;
      O_ERROR_FLAG_OUTPUT_O <= 1'b0;
      O_ERROR_FLAG_OUTPUT_OE <= 1'b0;
      O_STATUS_VALID <= 1'b0;
    end else if (I_CE) begin
      O_CHANNEL_SINK_OUTPUT <= next_out;
      O_CURRENT_SCALE_SETTING <= next_scale;
      O_SERIAL_OUT_PIN <= shreg[191];
      O_ERROR_FLAG_OUTPUT_O <= 1'b0;
      // Open-LED masked by blank so overtemp can be told apart
      O_ERROR_FLAG_OUTPUT_OE <= ot_s2 | (|lod_s2 & ~blank);
      O_STATUS_VALID <= (bitcnt != 8'h00) || stq.out_valid;
    end
  end

endmodule : lcpwm_top

// ===== test/lcpwm_host_model.sv
`timescale 1ns/1ps
module lcpwm_host_model (
  input wire logic i_serial_out_pin,
  output logic o_shift_clk,
  output logic o_sdata,
  output logic o_latch,
  output logic o_gs_clk
);
  logic [191:0] seen;
  // Link clocks idle low between frames
  initial begin
    o_shift_clk = 1'b0;
    o_sdata = 1'b0;
    o_latch = 1'b0;
    o_gs_clk = 1'b0;
    seen = '0;
  end
  // Odd start offset keeps the link out of phase with the system clock
  task automatic shift_bits(input logic [191:0] d, input int n);
    #13;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdata = d[i];
      #160;
      seen = {seen[190:0], i_serial_out_pin};
      o_shift_clk = 1'b1;
      #160;
      o_shift_clk = 1'b0;
    end
    o_sdata = ~o_sdata; // Released line must not look like held data
  endtask : shift_bits
  task automatic send_gs(input logic [191:0] d);
    shift_bits(d, 192);
  endtask : send_gs
  task automatic send_dc(input logic [95:0] d);
    shift_bits({96'h0, d}, 96);
  endtask : send_dc
  // High for eight system cycles, well over the two needed
  task automatic latch_pulse();
    o_latch = 1'b1;
    #320;
    o_latch = 1'b0;
    #320;
  endtask : latch_pulse
  task automatic gs_pulses(input int n);
    repeat (n) begin
      #160;
      o_gs_clk = 1'b1;
      #160;
      o_gs_clk = 1'b0;
    end
  endtask : gs_pulses
endmodule : lcpwm_host_model

// ===== test/lcpwm_top_monitor.sv
`timescale 1ns/1ps
module lcpwm_top_monitor (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_LATCH_STROBE,
  input wire logic I_PROG_LEVEL,
  input wire logic I_CURRENT_SCALE_SOURCE_SELECT,
  input wire logic I_BLANK,
  input wire logic [15:0] I_OPEN_LED_DETECT,
  input wire logic I_OVERTEMP_FLAG,
  input wire logic [15:0] O_CHANNEL_SINK_OUTPUT,
  input wire logic [95:0] O_CURRENT_SCALE_SETTING,
  input wire logic O_ERROR_FLAG_OUTPUT_O,
  input wire logic O_ERROR_FLAG_OUTPUT_OE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [4:0] blank_cnt;
  logic [4:0] next_blank_cnt;
  logic [3:0] err_age;
  logic [3:0] next_err_age;
  logic prog_seen;
  logic next_prog_seen;
  // Blank run length and error age saturate, so long runs never wrap
  always_comb begin
    next_blank_cnt = !I_BLANK ? 5'h00 : ((&blank_cnt) ? blank_cnt : blank_cnt + 5'h01);
    next_err_age = (I_OVERTEMP_FLAG || (|I_OPEN_LED_DETECT)) ? 4'h0 :
      ((&err_age) ? err_age : err_age + 4'h1);
    next_prog_seen = prog_seen | (I_PROG_LEVEL & I_CURRENT_SCALE_SOURCE_SELECT);
  end
  // Helper registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      blank_cnt <= 5'h00;
      err_age <= 4'hF;
      prog_seen <= 1'b0;
    end else begin
      blank_cnt <= next_blank_cnt;
      err_age <= next_err_age;
      prog_seen <= next_prog_seen;
    end
  end
  rst_clear_a: assert property ($rose(I_RST_N) |->
    O_CHANNEL_SINK_OUTPUT == 16'h0000 && O_CURRENT_SCALE_SETTING == {16{6'h3F}})
    else $error("outputs not cleared by reset");
  blank_off_a: assert property (blank_cnt >= 5'h18 |-> O_CHANNEL_SINK_OUTPUT == 16'h0000)
    else $error("sink on during blank");
  err_value_a: assert property (O_ERROR_FLAG_OUTPUT_O == 1'b0)
    else $error("error pin driven high");
  err_set_a: assert property (I_OVERTEMP_FLAG [*6] |-> O_ERROR_FLAG_OUTPUT_OE)
    else $error("overtemp not reported");
  err_clear_a: assert property (
    (!I_OVERTEMP_FLAG && (I_BLANK || I_OPEN_LED_DETECT == 16'h0000)) [*8]
    |-> !O_ERROR_FLAG_OUTPUT_OE) else $error("error pin not released");
  err_cause_a: assert property ($rose(O_ERROR_FLAG_OUTPUT_OE) |-> err_age < 4'h8)
    else $error("error pin pulled without cause");
  scale_dflt_a: assert property (
    (!prog_seen && !I_CURRENT_SCALE_SOURCE_SELECT) [*6]
    |-> O_CURRENT_SCALE_SETTING == {16{6'h3F}}) else $error("stored scale not default");
  scale_hold_a: assert property (
    (!I_LATCH_STROBE && I_CURRENT_SCALE_SOURCE_SELECT) [*5]
    |=> $stable(O_CURRENT_SCALE_SETTING)) else $error("scale moved with latch low");
endmodule : lcpwm_top_monitor
bind lcpwm_top lcpwm_top_monitor i_lcpwm_top_monitor (.*);

// ===== test/lcpwm_top_tb.sv
`timescale 1ns/1ps
module lcpwm_top_tb;
  import lcpwm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, mode = 1'b0, prog = 1'b0, sel = 1'b0;
  logic blank = 1'b1, ovt = 1'b0;
  logic [15:0] led = 16'h0000;
  logic [15:0] sink;
  logic [95:0] scale;
  logic sck, sdi, lat, gck, sdo, oe, err_o, stat;
  logic [191:0] gs_frame;
  logic [95:0] dc_frame;
  int failures = 0;
  int num_checks = 0;
  // System clock
  always #20 clk = ~clk;
  lcpwm_top i_lcpwm_top (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_SHIFT_CLK(sck),
    .I_SERIAL_IN_PIN(sdi), .I_LATCH_STROBE(lat), .I_PROGRAMMING_MODE_INPUT(mode),
    .I_PROG_LEVEL(prog), .I_CURRENT_SCALE_SOURCE_SELECT(sel), .I_BLANK(blank),
    .I_GS_REF_CLK(gck), .I_OPEN_LED_DETECT(led), .I_OVERTEMP_FLAG(ovt),
    .O_SERIAL_OUT_PIN(sdo), .O_CHANNEL_SINK_OUTPUT(sink), .O_CURRENT_SCALE_SETTING(scale),
    .O_ERROR_FLAG_OUTPUT_O(err_o), .O_ERROR_FLAG_OUTPUT_OE(oe), .O_STATUS_VALID(stat));
  lcpwm_host_model i_lcpwm_host_model (.i_serial_out_pin(sdo), .o_shift_clk(sck), .o_sdata(sdi),
    .o_latch(lat), .o_gs_clk(gck));
  task automatic check(input logic [191:0] seen, input logic [191:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Inputs set after step move one nanosecond after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic end_of_test();
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    int i;
    for (int k = 0; k < NUM_CH; k++) begin
      gs_frame[k*GS_W +: GS_W] = 12'(k);
      dc_frame[k*DC_W +: DC_W] = 6'(2 * k + 1);
    end
    step(8);
    rst_n = 1'b1;
    step(8);
    check(scale, {16{DC_DEFAULT}});
    mode = 1'b1;
    sel = 1'b1;
    i_lcpwm_host_model.send_dc(dc_frame);
    i_lcpwm_host_model.latch_pulse();
    step(8);
    check(scale, dc_frame);
    sel = 1'b0;
    step(8);
    check(scale, {16{DC_DEFAULT}});
    sel = 1'b1;
    i_lcpwm_host_model.send_dc(~dc_frame);
    step(8);
    check(scale, dc_frame);
    prog = 1'b1;
    step(8);
    prog = 1'b0;
    sel = 1'b0;
    step(8);
    check(scale, dc_frame);
    mode = 1'b0;
    i_lcpwm_host_model.send_gs(gs_frame);
    i_lcpwm_host_model.latch_pulse();
    step(2);
    blank = 1'b0;
    for (i = 0; i < 100 && sink[1] !== 1'b1; i++) step(1);
    if (i == 100) begin
      failures++;
      end_of_test();
    end
    // Each cycle one more channel joins, channel zero stays off at setting zero
    for (int n = 1; n < NUM_CH; n++) begin
      check(sink, 16'((32'h1 << (n + 1)) - 32'h2));
      step(STAGGER_CYC);
    end
    check(sink, 16'hFFFE);
    i_lcpwm_host_model.gs_pulses(8);
    step(24);
    check(sink, 16'hFE00);
    blank = 1'b1;
    step(30);
    check(sink, 16'h0000);
    blank = 1'b0;
    step(30);
    check(sink, 16'hFFFE);
    i_lcpwm_host_model.send_gs(~gs_frame);
    check(i_lcpwm_host_model.seen, gs_frame);
    ovt = 1'b1;
    step(10);
    check(oe, 1'b1);
    ovt = 1'b0;
    led = 16'h8000;
    step(40);
    i_lcpwm_host_model.latch_pulse();
    step(4);
    check(stat, 1'b1);
    // Status enters at the tail, so a full frame pushes it up to the serial out
    i_lcpwm_host_model.send_gs(gs_frame);
    i_lcpwm_host_model.shift_bits(192'h0, 16);
    check(i_lcpwm_host_model.seen[15:0], 16'h8000);
    led = 16'h0000;
    blank = 1'b1;
    step(12);
    check(oe, 1'b0);
    end_of_test();
  end
endmodule : lcpwm_top_tb
